// [pkg/shsc_pkg.sv]
// Purpose: constants and types shared by the standby halt/stop control
// Assumes: 250 MHz clk, one-cycle enable pulses stand in for slower rates
// Notes:   operand codes are the 4-bit instruction operand values
package shsc_pkg;
    localparam logic [3:0]  OPND_TIMER     = 4'h2;
    localparam logic [3:0]  OPND_GENERAL   = 4'h8;
    localparam logic [7:0]  TMM_RESET      = 8'hff;
    // timer tick is 64 us at a 4 MHz oscillator
    localparam int          TICK_NS        = 64000;
    localparam int          CLK_NS         = 4;
    localparam int          TICK_CYC       = TICK_NS / CLK_NS;
    localparam int          TICK_CYC_W     = 14;
    localparam logic [13:0] TICK_LAST      = 14'(TICK_CYC - 1);

    typedef enum logic [2:0] {
        SHSC_RUN   = 3'b000,
        SHSC_HALT  = 3'b001,
        SHSC_STOP  = 3'b011,
        SHSC_WAIT  = 3'b010,
        SHSC_HALT2 = 3'b110
    } shsc_mode_type;
endpackage

// [verilog/shsc_tick.sv]
// Purpose: divider making the 64 us timer tick enable
// Assumes: run held low outside the stabilisation wait
// Notes:   restarts from zero when run rises
`timescale 1ns/1ns
module shsc_tick (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    typedef struct packed {
        logic [13:0] cnt;
        logic        tick;
    } shsc_tick_st_type;
    shsc_tick_st_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 14'h0000;
        end else if (s_q.cnt == shsc_pkg::TICK_LAST) begin
            s_d.cnt = 14'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 14'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// [verilog/shsc_pins.sv]
// Purpose: level checks of the port pins used by entry and wake
// Assumes: pins sampled synchronously, configuration static during standby
// Notes:   purely combinational, registered by the caller
`timescale 1ns/1ns
module shsc_pins (
    input  wire logic [3:0] port_group_a_pins,
    input  wire logic [3:0] port_group_b_pins,
    input  wire logic [3:0] port_group_c_pins,
    input  wire logic [3:0] port_group_d_pins,
    input  wire logic [3:0] port_group_e_pins,
    input  wire logic [2:0] port1_group_a_pins,
    input  wire logic       port1_group_b_pin0,
    input  wire logic [11:0] bcd_is_input,
    input  wire logic       e_key_matrix,
    input  wire logic       p1_key_matrix,
    input  wire logic       p1_clear_level,
    output logic            all_idle,
    output logic            any_wake
);
    logic [11:0] bcd;
    logic [3:0]  p1;
    logic        a_hi, bcd_hi, e_hi, p1_idle;
    logic        a_lo, bcd_lo, e_lo, p1_clr;

    assign bcd     = {port_group_d_pins, port_group_c_pins, port_group_b_pins};
    assign p1      = {port1_group_b_pin0, port1_group_a_pins};
    assign a_hi    = &port_group_a_pins;
    assign bcd_hi  = &(bcd | ~bcd_is_input);
    assign e_hi    = !e_key_matrix || (&port_group_e_pins);
    assign p1_idle = !p1_key_matrix || (p1 == {4{~p1_clear_level}});
    assign a_lo    = !a_hi;
    assign bcd_lo  = |(~bcd & bcd_is_input);
    assign e_lo    = e_key_matrix && !(&port_group_e_pins);
    assign p1_clr  = p1_key_matrix && (p1 != {4{~p1_clear_level}});
    assign all_idle = a_hi && bcd_hi && e_hi && p1_idle;
    assign any_wake = a_lo || bcd_lo || e_lo || p1_clr;
endmodule

// [verilog/shsc_top.sv]
// Purpose: decides standby entry for halt/stop and times the stop release
// Assumes: cpu issues one-cycle halt_req/stop_req with the operand alongside
// Notes:   osc_enable low models the stopped oscillator; clk keeps running here
`timescale 1ns/1ns
module shsc_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        halt_req,
    input  wire logic        stop_req,
    input  wire logic [3:0]  operand,
    input  wire logic        timer_irq_flag,
    input  wire logic        interval_timer_irq_flag,
    input  wire logic        ext_pin_irq_flag,
    input  wire logic        timer_irq_enable,
    input  wire logic        interval_timer_irq_enable,
    input  wire logic        ext_pin_irq_enable,
    input  wire logic        ext_pin_edge_seen,
    input  wire logic [7:0]  timer_modulo_value,
    input  wire logic [3:0]  port_group_a_pins,
    input  wire logic [3:0]  port_group_b_pins,
    input  wire logic [3:0]  port_group_c_pins,
    input  wire logic [3:0]  port_group_d_pins,
    input  wire logic [3:0]  port_group_e_pins,
    input  wire logic [2:0]  port1_group_a_pins,
    input  wire logic        port1_group_b_pin0,
    input  wire logic [11:0] bcd_is_input,
    input  wire logic        e_key_matrix,
    input  wire logic        p1_key_matrix,
    input  wire logic        p1_clear_level,
    input  wire logic        halt_release,
    output logic             cpu_stall,
    output logic             osc_enable,
    output logic             instr_nop,
    output logic             timer_flag_clear,
    output logic             interval_timer_start,
    output logic             timer_restart,
    output logic             timer_flag_set,
    output logic [7:0]       timer_count,
    output logic [2:0]       mode
);
    typedef struct packed {
        shsc_pkg::shsc_mode_type st;
        logic [7:0] cnt;
        logic       nop;
        logic       fclr;
        logic       ibt;
        logic       trst;
        logic       fset;
        logic       halt_tmr;
        logic       stall;
        logic       osc;
    } shsc_st_type;
    shsc_st_type s_q, s_d;

    logic all_idle, any_wake, tick, flags_pending, wake;
    logic        in_run, in_halt, in_stop, in_wait;
    logic [11:0] bcd_pins;
    logic [3:0]  p1_pins;

    // operand decode shared by the entry logic and the checks
    function automatic logic is_timer_op(input logic [3:0] op);
        return op == shsc_pkg::OPND_TIMER;
    endfunction

    function automatic logic is_general_op(input logic [3:0] op);
        return op == shsc_pkg::OPND_GENERAL;
    endfunction

    shsc_pins u_pins (
        .port_group_a_pins  (port_group_a_pins),
        .port_group_b_pins  (port_group_b_pins),
        .port_group_c_pins  (port_group_c_pins),
        .port_group_d_pins  (port_group_d_pins),
        .port_group_e_pins  (port_group_e_pins),
        .port1_group_a_pins (port1_group_a_pins),
        .port1_group_b_pin0 (port1_group_b_pin0),
        .bcd_is_input       (bcd_is_input),
        .e_key_matrix       (e_key_matrix),
        .p1_key_matrix      (p1_key_matrix),
        .p1_clear_level     (p1_clear_level),
        .all_idle           (all_idle),
        .any_wake           (any_wake)
    );

    shsc_tick u_tick (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (s_q.st == shsc_pkg::SHSC_WAIT),
        .tick  (tick)
    );

    assign flags_pending = (timer_irq_flag && timer_irq_enable)
                        || (interval_timer_irq_flag && interval_timer_irq_enable)
                        || (ext_pin_irq_flag && ext_pin_irq_enable);
    assign wake = any_wake || (ext_pin_edge_seen && ext_pin_irq_enable);

    always_comb begin
        s_d = s_q;
        s_d.nop = 1'b0;
        s_d.fclr = 1'b0;
        s_d.ibt = 1'b0;
        s_d.trst = 1'b0;
        s_d.fset = 1'b0;
        case (s_q.st)
            shsc_pkg::SHSC_RUN: begin
                if (halt_req) begin
                    if (is_timer_op(operand) && !timer_irq_flag) begin
                        s_d.st = shsc_pkg::SHSC_HALT;
                        s_d.halt_tmr = 1'b1;
                    end else if (is_general_op(operand) && !flags_pending && all_idle) begin
                        s_d.st = shsc_pkg::SHSC_HALT;
                        s_d.halt_tmr = 1'b0;
                    end else begin
                        s_d.nop = 1'b1;
                    end
                end else if (stop_req) begin
                    // entry rejected if the wake would fire at once, avoiding a hang
                    if (is_general_op(operand) && all_idle
                        && !(ext_pin_irq_flag && ext_pin_irq_enable)) begin
                        s_d.st = shsc_pkg::SHSC_STOP;
                    end else begin
                        s_d.nop = 1'b1;
                    end
                end
            end
            shsc_pkg::SHSC_HALT: begin
                // halt release itself is sequenced by the cpu
                if (halt_release) begin
                    s_d.st = shsc_pkg::SHSC_RUN;
                end
            end
            shsc_pkg::SHSC_STOP: begin
                if (wake) begin
                    s_d.st = shsc_pkg::SHSC_WAIT;
                    s_d.fclr = 1'b1;
                    s_d.ibt = 1'b1;
                    s_d.trst = 1'b1;
                    s_d.cnt = 8'h00;
                end
            end
            shsc_pkg::SHSC_WAIT: begin
                // count 0..modulo inclusive, one per tick
                if (tick) begin
                    if (s_q.cnt == timer_modulo_value) begin
                        s_d.fset = 1'b1;
                        s_d.st = shsc_pkg::SHSC_RUN;
                        s_d.cnt = 8'h00;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
            end
            default: begin
                s_d.st = shsc_pkg::SHSC_RUN;
            end
        endcase
        // registered copies of the next mode keep decode logic off the pins
        s_d.stall = (s_d.st != shsc_pkg::SHSC_RUN);
        s_d.osc = (s_d.st != shsc_pkg::SHSC_STOP);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.osc <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_stall            = s_q.stall;
    assign osc_enable           = s_q.osc;
    assign instr_nop            = s_q.nop;
    assign timer_flag_clear     = s_q.fclr;
    assign interval_timer_start = s_q.ibt;
    assign timer_restart        = s_q.trst;
    assign timer_flag_set       = s_q.fset;
    assign timer_count          = s_q.cnt;
    assign mode                 = s_q.st;

    // decoded views used only by the checks below
    assign in_run   = (s_q.st == shsc_pkg::SHSC_RUN);
    assign in_halt  = (s_q.st == shsc_pkg::SHSC_HALT);
    assign in_stop  = (s_q.st == shsc_pkg::SHSC_STOP);
    assign in_wait  = (s_q.st == shsc_pkg::SHSC_WAIT);
    assign bcd_pins = {port_group_d_pins, port_group_c_pins, port_group_b_pins};
    assign p1_pins  = {port1_group_b_pin0, port1_group_a_pins};

    a_stop_release: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_STOP && wake) |=> timer_flag_clear && timer_restart
            && interval_timer_start && s_q.st == shsc_pkg::SHSC_WAIT)
        else $error("stop release actions missing");
    a_osc_off: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_STOP) |-> !osc_enable && cpu_stall)
        else $error("oscillator running in stop");
    a_halt_timer: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_RUN && halt_req && operand == shsc_pkg::OPND_TIMER && timer_irq_flag)
            |=> instr_nop && s_q.st == shsc_pkg::SHSC_RUN)
        else $error("timer halt entered with flag set");
    a_halt_general: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_RUN && halt_req && operand == shsc_pkg::OPND_GENERAL
            && (flags_pending || !all_idle)) |=> instr_nop)
        else $error("general halt entered while blocked");
    a_stop_nop: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_RUN && stop_req && !halt_req && !all_idle)
            |=> s_q.st == shsc_pkg::SHSC_RUN && instr_nop)
        else $error("stop entered with pins active");
    a_bad_operand: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_RUN && (halt_req || stop_req)
            && operand != shsc_pkg::OPND_TIMER && operand != shsc_pkg::OPND_GENERAL) |=> instr_nop)
        else $error("undefined operand entered standby");
    a_wait_end: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_WAIT && tick && s_q.cnt == timer_modulo_value)
            |=> timer_flag_set && !cpu_stall)
        else $error("wait did not end at modulo");
    a_wait_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_WAIT && !tick) |=> s_q.st == shsc_pkg::SHSC_WAIT && $stable(s_q.cnt))
        else $error("wait advanced without tick");
    a_wake_pin: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == shsc_pkg::SHSC_STOP && !(&port_group_a_pins)) |=> osc_enable)
        else $error("group a low did not wake");

    a_halt_timer_in: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && halt_req && is_timer_op(operand) && !timer_irq_flag)
            |=> mode == shsc_pkg::SHSC_HALT && !instr_nop)
        else $error("timer halt refused with flag clear");

    a_halt_gen_in: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && halt_req && is_general_op(operand) && !flags_pending && all_idle)
            |=> mode == shsc_pkg::SHSC_HALT && cpu_stall)
        else $error("general halt refused while allowed");

    a_halt_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && halt_req && is_general_op(operand) && !(&port_group_a_pins))
            |=> in_run && instr_nop)
        else $error("general halt entered with group a low");

    a_halt_pin_bcd: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && halt_req && is_general_op(operand) && |(~bcd_pins & bcd_is_input))
            |=> in_run && instr_nop)
        else $error("general halt entered with input pin low");

    a_halt_key_e: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && halt_req && is_general_op(operand) && e_key_matrix && !(&port_group_e_pins))
            |=> in_run && instr_nop)
        else $error("general halt entered with group e key low");

    a_halt_key_p1: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && halt_req && is_general_op(operand) && p1_key_matrix && p1_pins != {4{~p1_clear_level}})
            |=> in_run && instr_nop)
        else $error("general halt entered with port1 key active");

    a_halt_exit: assert property (@(posedge clk) disable iff (!rst_n)
        (in_halt && halt_release) |=> in_run && !cpu_stall)
        else $error("halt release ignored");

    a_stop_enter: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && stop_req && !halt_req && is_general_op(operand) && all_idle
            && !(ext_pin_irq_flag && ext_pin_irq_enable)) |=> in_stop && !osc_enable)
        else $error("allowed stop not entered");

    a_stop_pin_busy: assert property (@(posedge clk) disable iff (!rst_n)
        (in_run && stop_req && !halt_req && ext_pin_irq_flag && ext_pin_irq_enable)
            |=> in_run && instr_nop)
        else $error("stop entered with pin request pending");

    a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (in_stop && all_idle && !(ext_pin_edge_seen && ext_pin_irq_enable))
            |=> in_stop && !osc_enable && !timer_flag_clear)
        else $error("stop left without a wake source");

    a_wake_bcd: assert property (@(posedge clk) disable iff (!rst_n)
        (in_stop && |(~bcd_pins & bcd_is_input))
            |=> in_wait && osc_enable)
        else $error("input pin low did not wake");

    a_wake_ext: assert property (@(posedge clk) disable iff (!rst_n)
        (in_stop && ext_pin_edge_seen && ext_pin_irq_enable)
            |=> in_wait && osc_enable)
        else $error("pin interrupt edge did not wake");

    a_wake_key_e: assert property (@(posedge clk) disable iff (!rst_n)
        (in_stop && e_key_matrix && !(&port_group_e_pins))
            |=> in_wait && osc_enable)
        else $error("group e key did not wake");

    a_wake_key_p1: assert property (@(posedge clk) disable iff (!rst_n)
        (in_stop && p1_key_matrix && p1_pins != {4{~p1_clear_level}})
            |=> in_wait && osc_enable)
        else $error("port1 key did not wake");

    a_wait_start: assert property (@(posedge clk) disable iff (!rst_n)
        (!in_wait ##1 in_wait) |-> timer_count == 8'h00 && timer_flag_clear
            && timer_restart && interval_timer_start)
        else $error("wait entered without release actions");

    a_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
        timer_flag_clear |=> !timer_flag_clear && !timer_restart && in_wait)
        else $error("release pulse longer than one cycle");

    a_wait_osc: assert property (@(posedge clk) disable iff (!rst_n)
        in_wait |-> osc_enable && cpu_stall)
        else $error("wait without oscillator or stall");

    a_wait_step: assert property (@(posedge clk) disable iff (!rst_n)
        (in_wait && tick && timer_count != timer_modulo_value)
            |=> in_wait && timer_count == $past(timer_count) + 8'h01)
        else $error("wait count missed a tick");

    a_run_clear: assert property (@(posedge clk) disable iff (!rst_n)
        in_run |-> osc_enable && !cpu_stall)
        else $error("run mode with stall or oscillator off");

    a_run_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (!in_run && (halt_req || stop_req)) |=> !instr_nop)
        else $error("request outside run answered");

    c_halt_entry: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.st == shsc_pkg::SHSC_RUN ##1 s_q.st == shsc_pkg::SHSC_HALT);
    c_stop_wake: cover property (@(posedge clk) disable iff (!rst_n)
        s_q.st == shsc_pkg::SHSC_STOP ##1 s_q.st == shsc_pkg::SHSC_WAIT);
    c_resume: cover property (@(posedge clk) disable iff (!rst_n) timer_flag_set);
    c_nop: cover property (@(posedge clk) disable iff (!rst_n) instr_nop);
    c_wait_tick: cover property (@(posedge clk) disable iff (!rst_n) in_wait && tick);
endmodule

// [bench/shsc_keys.sv]
// Purpose: key matrix, port pins and interrupt pin as the block sees them
// Assumes: keys idle high, port1 keys idle at the inverse of the clear level
// Notes:   key_sel 0..3 picks the group (a, b, e, port1 b) whose pin 0 is pressed, 4 the interrupt pin edge; only one key at a time
`timescale 1ns/1ns
module shsc_keys (
    input  wire logic       key_down,
    input  wire logic [2:0] key_sel,
    input  wire logic       p1_clear_level,
    output logic [3:0]      port_group_a_pins,
    output logic [3:0]      port_group_b_pins,
    output logic [3:0]      port_group_c_pins,
    output logic [3:0]      port_group_d_pins,
    output logic [3:0]      port_group_e_pins,
    output logic [2:0]      port1_group_a_pins,
    output logic            port1_group_b_pin0,
    output logic            ext_pin_edge_seen
);
    // released keys return to their idle level (high, port1 at the inverse of the clear level), so no stale level is left behind
    assign port_group_a_pins  = {3'h7, ~(key_down && key_sel == 3'h0)};
    assign port_group_b_pins  = {3'h7, ~(key_down && key_sel == 3'h1)};
    assign port_group_c_pins  = 4'hf;
    assign port_group_d_pins  = 4'hf;
    assign port_group_e_pins  = {3'h7, ~(key_down && key_sel == 3'h2)};
    assign port1_group_a_pins = {3{~p1_clear_level}};
    assign port1_group_b_pin0 = (key_down && key_sel == 3'h3) ? p1_clear_level : ~p1_clear_level;
    assign ext_pin_edge_seen  = key_down && key_sel == 3'h4;
endmodule

// [bench/shsc_top_tb.sv]
// Purpose: self-checking bench for standby entry, wake and stabilisation wait
// Assumes: requests answered at the taking edge, read back 1 ns after it
// Notes:   mid-wait reset cuts most waits short to keep the run brief
`timescale 1ns/1ns
module shsc_top_tb;
    localparam logic [2:0] M_RUN  = shsc_pkg::SHSC_RUN;
    localparam logic [2:0] M_HALT = shsc_pkg::SHSC_HALT;
    localparam logic [2:0] M_STOP = shsc_pkg::SHSC_STOP;
    localparam logic [2:0] M_WAIT = shsc_pkg::SHSC_WAIT;
    localparam logic [3:0] TMR    = shsc_pkg::OPND_TIMER;
    localparam logic [3:0] GEN    = shsc_pkg::OPND_GENERAL;
    logic        clk = 1'b0, rst_n = 1'b0, halt_req = 1'b0, stop_req = 1'b0, halt_release = 1'b0;
    logic [3:0]  operand = 4'h0;
    logic        timer_irq_flag = 1'b0, interval_timer_irq_flag = 1'b0, ext_pin_irq_flag = 1'b0;
    logic        timer_irq_enable = 1'b0, interval_timer_irq_enable = 1'b0, ext_pin_irq_enable = 1'b0;
    logic [7:0]  timer_modulo_value = 8'h01;
    logic [11:0] bcd_is_input = 12'hfff;
    logic        e_key_matrix = 1'b1, p1_key_matrix = 1'b1, p1_clear_level = 1'b1, key_down = 1'b0;
    logic [2:0]  key_sel = 3'h0;
    logic [3:0]  port_group_a_pins, port_group_b_pins, port_group_c_pins, port_group_d_pins, port_group_e_pins;
    logic [2:0]  port1_group_a_pins, mode;
    logic        port1_group_b_pin0, ext_pin_edge_seen, cpu_stall, osc_enable, instr_nop;
    logic        timer_flag_clear, interval_timer_start, timer_restart, timer_flag_set;
    logic [7:0]  timer_count;
    int          bad_count = 0, n_tests = 0, k;

    shsc_keys shsc_keys_inst (.key_down, .key_sel, .p1_clear_level, .port_group_a_pins, .port_group_b_pins,
        .port_group_c_pins, .port_group_d_pins, .port_group_e_pins, .port1_group_a_pins, .port1_group_b_pin0,
        .ext_pin_edge_seen);
    shsc_top shsc_top_inst (.clk, .rst_n, .halt_req, .stop_req, .operand, .timer_irq_flag, .interval_timer_irq_flag,
        .ext_pin_irq_flag, .timer_irq_enable, .interval_timer_irq_enable, .ext_pin_irq_enable, .ext_pin_edge_seen,
        .timer_modulo_value, .port_group_a_pins, .port_group_b_pins, .port_group_c_pins, .port_group_d_pins,
        .port_group_e_pins, .port1_group_a_pins, .port1_group_b_pin0, .bcd_is_input, .e_key_matrix, .p1_key_matrix,
        .p1_clear_level, .halt_release, .cpu_stall, .osc_enable, .instr_nop, .timer_flag_clear,
        .interval_timer_start, .timer_restart, .timer_flag_set, .timer_count, .mode);

    always #2 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one-cycle request; a halt that was entered is released again
    task automatic issue(input logic stp, input logic [3:0] op, input logic [2:0] em);
        halt_req = ~stp;
        stop_req = stp;
        operand = op;
        step(1);
        halt_req = 1'b0;
        stop_req = 1'b0;
        check(8'(instr_nop), 8'(em == M_RUN));
        check(8'(mode), 8'(em));
        check(8'(cpu_stall), 8'(em != M_RUN));
        if (em == M_HALT) begin
            halt_release = 1'b1;
            step(1);
            check(8'(mode), 8'(M_RUN));
            halt_release = 1'b0;
        end else begin
            step(1);
        end
    endtask

    initial begin
        #240000;
        bad_count++;
        print_verdict();
    end

    initial begin
        step(12);
        rst_n = 1'b1;
        issue(1'b0, TMR, M_HALT);
        timer_irq_flag = 1'b1;
        issue(1'b0, TMR, M_RUN);
        timer_irq_enable = 1'b1;
        issue(1'b0, GEN, M_RUN);
        timer_irq_enable = 1'b0;
        issue(1'b0, GEN, M_HALT);
        timer_irq_flag = 1'b0;
        interval_timer_irq_flag = 1'b1;
        interval_timer_irq_enable = 1'b1;
        issue(1'b0, GEN, M_RUN);
        interval_timer_irq_flag = 1'b0;
        ext_pin_irq_flag = 1'b1;
        ext_pin_irq_enable = 1'b1;
        issue(1'b1, GEN, M_RUN);
        ext_pin_irq_flag = 1'b0;
        for (int i = 0; i < 16; i++) begin
            issue(1'b0, 4'(i), (i == 2 || i == 8) ? M_HALT : M_RUN);
            if (i != 8) issue(1'b1, 4'(i), M_RUN);
        end
        key_down = 1'b1;
        for (int i = 0; i < 4; i++) begin
            key_sel = 3'(i);
            issue(1'b0, GEN, M_RUN);
            issue(1'b1, GEN, M_RUN);
        end
        // pins outside input or key-matrix use must not block entry
        {bcd_is_input, e_key_matrix, p1_key_matrix} = 14'h0000;
        for (int i = 1; i < 4; i++) begin
            key_sel = 3'(i);
            issue(1'b0, GEN, M_HALT);
        end
        key_down = 1'b0;
        {bcd_is_input, e_key_matrix, p1_key_matrix} = 14'h3fff;
        for (int w = 0; w < 5; w++) begin
            timer_modulo_value = (w == 0) ? 8'h01 : 8'h00;
            issue(1'b1, GEN, M_STOP);
            check(8'(osc_enable), 8'h00);
            step(3);
            check(8'(mode), 8'(M_STOP));
            key_sel = 3'(w);
            key_down = 1'b1;
            k = 0;
            while (mode !== M_WAIT && k < 8) begin
                step(1);
                k++;
            end
            check(8'(mode), 8'(M_WAIT));
            check({5'h00, timer_flag_clear, interval_timer_start, timer_restart}, 8'h07);
            check(8'(osc_enable), 8'h01);
            key_down = 1'b0;
            if (w == 0) begin
                check(timer_count, 8'h00);
                step(shsc_pkg::TICK_CYC + 1);
                check(timer_count, 8'h01);
                k = shsc_pkg::TICK_CYC + 1;
                while (timer_flag_set !== 1'b1 && k < 40000) begin
                    step(1);
                    k++;
                end
                check(8'(k >= 2 * shsc_pkg::TICK_CYC - 1 && k <= 2 * shsc_pkg::TICK_CYC + 2), 8'h01);
                check(8'(mode), 8'(M_RUN));
            end else begin
                // a reset mid-wait skips the long count for the remaining sources
                rst_n = 1'b0;
                step(12);
                rst_n = 1'b1;
            end
        end
        print_verdict();
    end
endmodule
